// *** core/srsync_rx.sv ***
// Purpose: lane front end of a serial converter link receiver with apb registers
// Assumes: lane clocks and data, and the alignment reference, are asynchronous pins
// Notes:   one pclk domain; frame clock is a one-cycle enable from a divider
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module srsync_rx (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [3:0]          lane_clk,
  input  wire logic [3:0]          lane_data,
  input  wire logic                mds_in,
  output logic                     mds_out,
  output logic                     sync_req_n,
  output logic [3:0][9:0]          lane_word_out,
  output logic [3:0]               lane_word_valid,
  output logic                     irq
);

  // ==========================================================================
  // declarations
  localparam int unsigned NUM_LANES = srsync_pkg::NUM_LANES;
  localparam int unsigned DLY_DEPTH = srsync_pkg::DLY_DEPTH;
  localparam int          LAT_MIN_I = int'(srsync_pkg::LAT_MIN);
  localparam int          LAT_MAX_I = int'(srsync_pkg::LAT_MAX);

  logic [3:0]        ctrl, next_ctrl;
  logic [7:0]        lane_map, next_lane_map;
  logic [3:0]        lane_pol, next_lane_pol;
  logic [3:0]        skew, next_skew;
  logic [3:0]        irq_en, next_irq_en;
  logic [3:0]        irq_stat, next_irq_stat;
  logic [31:0]       next_prdata;
  logic              next_sync_req_n;
  wire  [3:0]        lane_synced;
  wire  [3:0]        lane_locked;
  wire  [3:0]        sync_lost;
  wire  [3:0]        lock_lost;
  wire  [3:0][9:0]   lane_word;
  logic [3:0]        active;
  logic [3:0]        ev;
  logic              data_force;
  logic              frame_force;
  logic              apb_wr;
  logic [8:0]        frame_cnt, next_frame_cnt;
  logic              frame_tick;
  logic [4:0]        wp, next_wp;
  logic [9:0]        dbuf [NUM_LANES][DLY_DEPTH];
  logic [9:0]        next_dbuf [NUM_LANES][DLY_DEPTH];
  logic [3:0][9:0]   next_word_out;
  logic [3:0]        next_word_valid;
  logic [5:0]        dly_sum;
  logic [4:0]        dly;
  logic [4:0]        rd_idx;
  logic [3:0]        adj, next_adj;
  logic              mds_s1, mds_s2, mds_s3;
  logic              next_mds_out;
  logic              mds_rise;
  logic              adj_ev;

  // true for any offset this block answers
  function automatic logic addr_mapped(input logic [7:0] a);
    return (a == srsync_pkg::ADDR_CTRL)     || (a == srsync_pkg::ADDR_MAP)    ||
           (a == srsync_pkg::ADDR_SKEW)     || (a == srsync_pkg::ADDR_STATUS) ||
           (a == srsync_pkg::ADDR_IRQ_STAT) || (a == srsync_pkg::ADDR_IRQ_CLR) ||
           (a == srsync_pkg::ADDR_IRQ_EN);
  endfunction

  // either polarity of the sync character
  function automatic logic is_sync_char(input logic [9:0] w);
    return (w == srsync_pkg::K285_RDN) || (w == srsync_pkg::K285_RDP);
  endfunction

  function automatic logic [3:0] ones10(input logic [9:0] w);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 10; i++)
      n = n + {3'b000, w[i]};
    return n;
  endfunction

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  assign data_force  = ctrl[srsync_pkg::CTRL_DATA_FORCE];
  assign frame_force = ctrl[srsync_pkg::CTRL_FRAME_FORCE];

  // ==========================================================================
  // per-lane clock recovery, deserialiser and word sync
  for (genvar p = 0; p < NUM_LANES; p++)
  begin : g_lane
    logic                              clk_s1, clk_s2, clk_s3, dat_s1, dat_s2;
    logic                              rise, word_done, locked, next_locked;
    logic                              rd, next_rd;
    logic [9:0]                        sh, next_sh, word, next_word;
    logic [3:0]                        bitcnt, next_bitcnt, n1;
    logic [6:0]                        gap, next_gap;
    logic [4:0]                        edges, next_edges;
    logic [2:0]                        cnt, next_cnt;
    srsync_pkg::srsync_lane_state_type state, next_state;

    // edge finder and lock loop; a silent clock for two bit times drops lock
    always_comb
    begin
      rise        = clk_s2 & ~clk_s3;
      next_sh     = rise ? {sh[8:0], dat_s2 ^ lane_pol[p]} : sh;
      next_gap    = rise ? 7'd0 : (gap == 7'(srsync_pkg::GAP_CYCLES)) ? gap : gap + 7'd1;
      next_edges  = edges;
      next_locked = locked;
      if (rise && !locked)
      begin
        next_edges = edges + 5'd1;
        if (edges == 5'(srsync_pkg::LOCK_EDGES - 1))
          next_locked = 1'b1;
      end
      if (gap == 7'(srsync_pkg::GAP_CYCLES) || data_force)
      begin
        next_locked = 1'b0;
        next_edges  = 5'd0;
      end
      // in hunt the boundary follows the sync character, afterwards every tenth bit
      word_done   = rise && ((state == srsync_pkg::SRSYNC_HUNT) ? is_sync_char(next_sh)
                                                                : (bitcnt == 4'd9));
      next_bitcnt = word_done ? 4'd0 : rise ? bitcnt + 4'd1 : bitcnt;
      next_word   = word_done ? next_sh : word;
      n1          = ones10(next_sh);
      next_state  = state;
      next_cnt    = cnt;
      next_rd     = rd;
      if (word_done)
      begin
        unique case (state)
          srsync_pkg::SRSYNC_HUNT:
          begin
            next_state = srsync_pkg::SRSYNC_CHECK;
            next_cnt   = 3'd1;
            next_rd    = (next_sh == srsync_pkg::K285_RDN);
          end
          srsync_pkg::SRSYNC_CHECK:
          begin
            next_rd  = (next_sh == srsync_pkg::K285_RDN);
            next_cnt = cnt + 3'd1;
            if (!is_sync_char(next_sh))
              next_state = srsync_pkg::SRSYNC_HUNT;
            else if (cnt == 3'(srsync_pkg::SYNC_WORDS - 1))
            begin
              next_state = srsync_pkg::SRSYNC_SYNCED;
              next_cnt   = 3'd0;
            end
          end
          srsync_pkg::SRSYNC_SYNCED:
          begin
            // a word of wrong weight or wrong disparity counts as an error
            if (n1 < 4'd4 || n1 > 4'd6 || (n1 == 4'd6 && rd) || (n1 == 4'd4 && !rd))
              next_cnt = cnt + 3'd1;
            else
              next_cnt = 3'd0;
            if (n1 == 4'd6)
              next_rd = 1'b1;
            else if (n1 == 4'd4)
              next_rd = 1'b0;
            if (next_cnt == 3'(srsync_pkg::ERR_LIMIT))
              next_state = srsync_pkg::SRSYNC_HUNT;
          end
          default:
            next_state = srsync_pkg::SRSYNC_HUNT;
        endcase
      end
      if (!locked || data_force)
      begin
        next_state = srsync_pkg::SRSYNC_HUNT;
        next_cnt   = 3'd0;
      end
    end

    // two flops on each pin before any logic looks at it
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        clk_s1 <= 1'b0;
        clk_s2 <= 1'b0;
        clk_s3 <= 1'b0;
        dat_s1 <= 1'b0;
        dat_s2 <= 1'b0;
        sh     <= 10'h000;
        word   <= 10'h000;
        bitcnt <= 4'h0;
        gap    <= 7'h00;
        edges  <= 5'h00;
        locked <= 1'b0;
        rd     <= 1'b0;
        cnt    <= 3'h0;
        state  <= srsync_pkg::SRSYNC_HUNT;
      end
      else
      begin
        clk_s1 <= lane_clk[p];
        clk_s2 <= clk_s1;
        clk_s3 <= clk_s2;
        dat_s1 <= lane_data[p];
        dat_s2 <= dat_s1;
        sh     <= next_sh;
        word   <= next_word;
        bitcnt <= next_bitcnt;
        gap    <= next_gap;
        edges  <= next_edges;
        locked <= next_locked;
        rd     <= next_rd;
        cnt    <= next_cnt;
        state  <= next_state;
      end
    end

    assign lane_synced[p] = (state == srsync_pkg::SRSYNC_SYNCED);
    assign lane_locked[p] = locked;
    assign lane_word[p]   = word;  // held for the frame side
    assign sync_lost[p]   = (state == srsync_pkg::SRSYNC_SYNCED) &&
                            (next_state != srsync_pkg::SRSYNC_SYNCED);
    assign lock_lost[p]   = locked && !next_locked;

    property p_lock_first;
      !locked |=> (state == srsync_pkg::SRSYNC_HUNT);
    endproperty
    a_lock_first: assert property (p_lock_first) else $error("lane left hunt without lock");

    property p_word_on_edge;
      $changed(word) |-> $past(rise);
    endproperty
    a_word_on_edge: assert property (p_word_on_edge) else $error("word changed off a bit edge");

    property p_rd_init;
      (state == srsync_pkg::SRSYNC_CHECK) && word_done && (next_sh == srsync_pkg::K285_RDN)
        |=> rd;
    endproperty
    a_rd_init: assert property (p_rd_init) else $error("disparity not set by sync char");
  end

  // ==========================================================================
  // lanes in use and the sync request
  always_comb
  begin
    active = 4'h0;
    for (int l = 0; l < NUM_LANES; l++)
      if (!ctrl[srsync_pkg::CTRL_LMF_211] || l < 2)
        active[lane_map[2*l +: 2]] = 1'b1;
    // a single flop drives the pin, so the far side may sample it freely
    next_sync_req_n = !frame_force && !data_force && (|active) &&
                      (&(lane_synced | ~active));
  end

  // ==========================================================================
  // frame timebase, alignment delay and sample output
  always_comb
  begin
    frame_tick     = (frame_cnt == 9'(srsync_pkg::FRAME_CYCLES - 1));
    next_frame_cnt = frame_tick ? 9'd0 : frame_cnt + 9'd1;
    next_wp        = frame_tick ? wp + 5'd1 : wp;
    dly_sum        = 6'(srsync_pkg::LAT_MIN) + {2'b00, skew} + {2'b00, adj};
    dly            = (dly_sum > 6'(srsync_pkg::LAT_MAX)) ? 5'(srsync_pkg::LAT_MAX)
                                                         : dly_sum[4:0];
    rd_idx         = wp - dly;
    next_dbuf      = dbuf;
    next_word_out  = lane_word_out;
    next_word_valid = lane_word_valid;
    for (int l = 0; l < NUM_LANES; l++)
    begin
      if (frame_tick)
      begin
        next_dbuf[l][wp]   = lane_word[lane_map[2*l +: 2]];
        next_word_valid[l] = sync_req_n && !frame_force &&
                             (!ctrl[srsync_pkg::CTRL_LMF_211] || l < 2);
        next_word_out[l]   = next_word_valid[l] ? dbuf[l][rd_idx] : 10'h000;
      end
      if (frame_force)
      begin
        next_word_out[l]   = 10'h000;
        next_word_valid[l] = 1'b0;
      end
    end
    // master drives a square reference off its read pointer, slaves chase it
    next_mds_out = ctrl[srsync_pkg::CTRL_MASTER] && (rd_idx < 5'd16);
    mds_rise     = mds_s2 & ~mds_s3;
    next_adj     = adj;
    adj_ev       = 1'b0;
    if (!ctrl[srsync_pkg::CTRL_MASTER] && mds_rise && sync_req_n)
    begin
      if (rd_idx != 5'd0 && rd_idx < 5'd16 && adj != 4'hF)
      begin
        next_adj = adj + 4'h1;  // own reference early
        adj_ev   = 1'b1;
      end
      else if (rd_idx >= 5'd16 && adj != 4'h0)
      begin
        next_adj = adj - 4'h1;  // own reference late
        adj_ev   = 1'b1;
      end
    end
    if (frame_force)
      next_adj = 4'h0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frame_cnt       <= 9'h000;
      wp              <= 5'h00;
      lane_word_out   <= '0;
      lane_word_valid <= 4'h0;
      mds_s1          <= 1'b0;
      mds_s2          <= 1'b0;
      mds_s3          <= 1'b0;
      mds_out         <= 1'b0;
      adj             <= 4'h0;
      sync_req_n      <= 1'b0;
      for (int l = 0; l < NUM_LANES; l++)
        for (int d = 0; d < DLY_DEPTH; d++)
          dbuf[l][d] <= 10'h000;
    end
    else
    begin
      frame_cnt       <= next_frame_cnt;
      wp              <= next_wp;
      lane_word_out   <= next_word_out;
      lane_word_valid <= next_word_valid;
      mds_s1          <= mds_in;
      mds_s2          <= mds_s1;
      mds_s3          <= mds_s2;
      mds_out         <= next_mds_out;
      adj             <= next_adj;
      sync_req_n      <= next_sync_req_n;
      dbuf            <= next_dbuf;
    end
  end

  // ==========================================================================
  // apb slave, zero wait states; read data is loaded in the setup cycle
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;
  assign ev     = {adj_ev, |lock_lost, |(sync_lost & active), next_sync_req_n & ~sync_req_n};
  assign irq    = |(irq_stat & irq_en);

  always_comb
  begin
    pslverr       = psel && penable && !addr_mapped(paddr);
    next_ctrl     = ctrl;
    next_lane_map = lane_map;
    next_lane_pol = lane_pol;
    next_skew     = skew;
    next_irq_en   = irq_en;
    next_irq_stat = irq_stat;
    next_prdata   = prdata;
    if (apb_wr)
    begin
      unique case (paddr)
        srsync_pkg::ADDR_CTRL:    next_ctrl   = pwdata[3:0];
        srsync_pkg::ADDR_MAP:
        begin
          next_lane_map = pwdata[7:0];
          next_lane_pol = pwdata[srsync_pkg::MAP_POL_LSB +: 4];
        end
        srsync_pkg::ADDR_SKEW:    next_skew   = pwdata[3:0];
        srsync_pkg::ADDR_IRQ_CLR: next_irq_stat = irq_stat & ~pwdata[3:0];
        srsync_pkg::ADDR_IRQ_EN:  next_irq_en = pwdata[3:0];
        default:                  next_ctrl   = ctrl;
      endcase
    end
    next_irq_stat = next_irq_stat | ev;  // set wins over a clear in the same cycle
    if (psel && !penable && !pwrite)
    begin
      next_prdata = 32'h0000_0000;
      unique case (paddr)
        srsync_pkg::ADDR_CTRL:     next_prdata[3:0]  = ctrl;
        srsync_pkg::ADDR_MAP:      next_prdata[11:0] = {lane_pol, lane_map};
        srsync_pkg::ADDR_SKEW:     next_prdata[3:0]  = skew;
        srsync_pkg::ADDR_STATUS:
        begin
          next_prdata[srsync_pkg::STAT_LOCK_LSB +: 4] = lane_locked;
          next_prdata[srsync_pkg::STAT_SYNC_LSB +: 4] = lane_synced;
          next_prdata[srsync_pkg::STAT_REQ_BIT]       = sync_req_n;
          next_prdata[srsync_pkg::STAT_ADJ_LSB +: 4]  = adj;
        end
        srsync_pkg::ADDR_IRQ_STAT: next_prdata[3:0]  = irq_stat;
        srsync_pkg::ADDR_IRQ_EN:   next_prdata[3:0]  = irq_en;
        default:                   next_prdata       = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl     <= srsync_pkg::CTRL_RST;
      lane_map <= srsync_pkg::MAP_RST;
      lane_pol <= srsync_pkg::POL_RST;
      skew     <= srsync_pkg::SKEW_RST;
      irq_en   <= srsync_pkg::IEN_RST;
      irq_stat <= 4'h0;
      prdata   <= 32'h0000_0000;
    end
    else
    begin
      ctrl     <= next_ctrl;
      lane_map <= next_lane_map;
      lane_pol <= next_lane_pol;
      skew     <= next_skew;
      irq_en   <= next_irq_en;
      irq_stat <= next_irq_stat;
      prdata   <= next_prdata;
    end
  end

  // ==========================================================================
  // checks
  property p_force_holds_req;
    (frame_force || data_force) |=> !sync_req_n;
  endproperty
  a_force_holds_req: assert property (p_force_holds_req) else $error("request released under force");

  property p_release_needs_sync;
    $rose(sync_req_n) |-> $past(&(lane_synced | ~active)) && $past(|active);
  endproperty
  a_release_needs_sync: assert property (p_release_needs_sync) else $error("released before sync");

  property p_reinit;
    (|(sync_lost & active)) && !apb_wr |-> ##2 !sync_req_n;
  endproperty
  a_reinit: assert property (p_reinit) else $error("lost lane did not reassert request");

  property p_latency_window;
    dly >= LAT_MIN_I && dly <= LAT_MAX_I;
  endproperty
  a_latency_window: assert property (p_latency_window) else $error("delay outside 13..28");

  property p_lmf_211_quiet;
    ctrl[srsync_pkg::CTRL_LMF_211] && frame_tick |=> lane_word_valid[3:2] == 2'b00;
  endproperty
  a_lmf_211_quiet: assert property (p_lmf_211_quiet) else $error("upper lanes live in 211");

  property p_slave_quiet;
    !ctrl[srsync_pkg::CTRL_MASTER] |=> !mds_out;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet) else $error("slave drives reference");

  property p_status_read;
    psel && !penable && !pwrite && paddr == srsync_pkg::ADDR_STATUS
      |=> prdata[srsync_pkg::STAT_REQ_BIT] == $past(sync_req_n);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status shows stale request");

endmodule

// *** core/srsync_pkg.sv ***
// Purpose: shared constants and types of the serial lane sync receiver
// Assumes: pclk at 200 MHz, recovered lane clocks sampled as plain inputs
// Notes:   every offset, field position and count lives here, and the reset value of each apb register but irq_stat
package srsync_pkg;

  // ==========================================================================
  // sizes and timing
  localparam int unsigned NUM_LANES      = 4;
  localparam int unsigned WORD_BITS      = 10;
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned LINK_PERIOD_NS = 160;
  localparam int unsigned FRAME_CYCLES   = LINK_PERIOD_NS * WORD_BITS / CLK_PERIOD_NS;
  localparam int unsigned GAP_CYCLES     = 2 * LINK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned LOCK_EDGES     = 16;
  localparam int unsigned SYNC_WORDS     = 4;
  localparam int unsigned ERR_LIMIT      = 4;
  localparam int unsigned LAT_MIN        = 13;
  localparam int unsigned LAT_MAX        = 28;
  localparam int unsigned DLY_DEPTH      = 32;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_MAP      = 8'h04;
  localparam logic [7:0] ADDR_SKEW     = 8'h08;
  localparam logic [7:0] ADDR_STATUS   = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h18;

  // ==========================================================================
  // field positions
  localparam int unsigned CTRL_FRAME_FORCE = 0;
  localparam int unsigned CTRL_DATA_FORCE  = 1;
  localparam int unsigned CTRL_LMF_211     = 2;
  localparam int unsigned CTRL_MASTER      = 3;
  localparam int unsigned MAP_POL_LSB      = 8;
  localparam int unsigned STAT_LOCK_LSB    = 0;
  localparam int unsigned STAT_SYNC_LSB    = 4;
  localparam int unsigned STAT_REQ_BIT     = 8;
  localparam int unsigned STAT_ADJ_LSB     = 12;
  localparam int unsigned IRQ_LINK_UP      = 0;
  localparam int unsigned IRQ_SYNC_LOST    = 1;
  localparam int unsigned IRQ_LOCK_LOST    = 2;
  localparam int unsigned IRQ_MDS_ADJ      = 3;

  // ==========================================================================
  // reset values
  localparam logic [3:0] CTRL_RST = 4'h3;
  localparam logic [7:0] MAP_RST  = 8'hE4;
  localparam logic [3:0] POL_RST  = 4'h0;
  localparam logic [3:0] SKEW_RST = 4'h0;
  localparam logic [3:0] IEN_RST  = 4'h0;

  // ==========================================================================
  // sync character, first received bit in bit 9
  localparam logic [9:0] K285_RDN = 10'h0FA;
  localparam logic [9:0] K285_RDP = 10'h305;

  typedef enum logic [1:0] {
    SRSYNC_HUNT   = 2'b00,
    SRSYNC_CHECK  = 2'b01,
    SRSYNC_SYNCED = 2'b11
  } srsync_lane_state_type;

endpackage

// *** test/srsync_tx_model.sv ***
// Purpose: transmitter model sending sync characters on all four lanes
// Assumes: lane clock of 160 ns, running only while run is high
// Notes:   bad sends an unbalanced word to break lane decoding
`timescale 1ns/1ps
module srsync_tx_model (
  input  wire logic       run,
  input  wire logic       bad,
  output logic      [3:0] lane_clk,
  output logic      [3:0] lane_data
);
  logic [9:0] word;
  int         idx;
  // ==========================================================================
  // data moves on the falling lane edge so it is settled at the rising one
  initial
  begin
    lane_clk  = 4'h0;
    lane_data = 4'h0;
    word      = srsync_pkg::K285_RDN;
    idx       = 9;
    forever
    begin
      #80;
      lane_clk = run ? ~lane_clk : 4'h0; // clock stands still outside frames
      if (!run)
        lane_data = ~lane_data; // idle line must not hold its last bit
      else if (lane_clk == 4'h0)
      begin
        lane_data = {4{word[idx]}}; // first bit is bit 9
        idx       = (idx == 0) ? 9 : idx - 1;
        if (idx == 9)
          word = bad ? 10'h3FF : (word == srsync_pkg::K285_RDN) ?
                 srsync_pkg::K285_RDP : srsync_pkg::K285_RDN; // alternate disparity
      end
    end
  end
endmodule

// *** test/test_srsync_rx.sv ***
// Purpose: register and link bring-up test of the lane sync receiver
// Assumes: zero wait state apb, lane clock 160 ns from the model
// Notes:   reference raised once and held high at a master-found phase to step the slave delay
`timescale 1ns/1ps
module test_srsync_rx;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic            mds_in, mds_out, sync_req_n, irq, run, bad;
  logic [7:0]      paddr;
  logic [31:0]     pwdata, prdata;
  logic [3:0]      lane_clk, lane_data, lane_word_valid;
  logic [3:0][9:0] lane_word_out;
  int              miscompares, n_compared;

  srsync_rx dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lane_clk(lane_clk), .lane_data(lane_data), .mds_in(mds_in),
    .mds_out(mds_out), .sync_req_n(sync_req_n), .lane_word_out(lane_word_out),
    .lane_word_valid(lane_word_valid), .irq(irq));
  srsync_tx_model tx (.run(run), .bad(bad), .lane_clk(lane_clk), .lane_data(lane_data));

  // ==========================================================================
  // clock and shared tasks
  always #2.5 pclk = ~pclk;

  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed; only the watchdog ends a hung wait
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic ee);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, exp);
    chk(32'(e), 32'(ee));
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  // sampled on the falling edge, away from the registered update
  task automatic wait_req(input logic lvl, input int lim);
    int n;
    n = 0;
    while (sync_req_n !== lvl && n < lim)
    begin
      @(negedge pclk);
      n++;
    end
    chk(32'(sync_req_n), 32'(lvl));
  endtask

  // one falling edge first, so a mode written just before has taken hold
  task automatic wait_mds(input logic lvl);
    int n;
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (mds_out !== lvl && n < 11000);
    chk(32'(mds_out), 32'(lvl));
  endtask

  // either disparity of the sync character
  function automatic logic is_k(input logic [9:0] w);
    return (w == srsync_pkg::K285_RDN) || (w == srsync_pkg::K285_RDP);
  endfunction

  // ==========================================================================
  // main sequence
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, mds_in, run, bad} = 8'h00;
    paddr  = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(32'(sync_req_n), 32'h0000_0000);
    chk(32'(pready), 32'h0000_0001);
    rd(srsync_pkg::ADDR_CTRL, 32'h0000_0003, 1'b0);
    rd(srsync_pkg::ADDR_MAP, 32'h0000_00E4, 1'b0);
    rd(8'h40, 32'h0000_0000, 1'b1);
    wr(srsync_pkg::ADDR_MAP, 32'h0000_0F1B);
    rd(srsync_pkg::ADDR_MAP, 32'h0000_0F1B, 1'b0);
    wr(srsync_pkg::ADDR_IRQ_EN, 32'h0000_0003);
    rd(srsync_pkg::ADDR_IRQ_EN, 32'h0000_0003, 1'b0);
    wr(srsync_pkg::ADDR_CTRL, 32'h0000_0000);
    run <= 1'b1;
    wait_req(1'b1, 4000);
    rd(srsync_pkg::ADDR_STATUS, 32'h0000_01FF, 1'b0);
    chk(32'(irq), 32'h0000_0001);
    // long enough that the delayed words read out of the delay line are sync characters
    repeat (4000) @(negedge pclk);
    chk(32'(lane_word_valid), 32'h0000_000F);
    chk(32'(is_k(lane_word_out[0])), 32'h0000_0001);
    chk(32'(is_k(lane_word_out[3])), 32'h0000_0001);
    wr(srsync_pkg::ADDR_IRQ_CLR, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0000);
    bad <= 1'b1;
    wait_req(1'b0, 3000);
    rd(srsync_pkg::ADDR_IRQ_STAT, 32'h0000_0002, 1'b0);
    bad <= 1'b0;
    wait_req(1'b1, 4000);
    // master reference rises as the read index wraps; three frames later a slave is early
    wr(srsync_pkg::ADDR_CTRL, 32'h0000_0008);
    wait_mds(1'b0);
    wait_mds(1'b1);
    wr(srsync_pkg::ADDR_CTRL, 32'h0000_0000);
    repeat (1000) @(negedge pclk);
    chk(32'(mds_out), 32'h0000_0000);
    @(posedge pclk);
    mds_in <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(srsync_pkg::ADDR_STATUS, 32'h0000_11FF, 1'b0);
    rd(srsync_pkg::ADDR_IRQ_STAT, 32'h0000_000B, 1'b0);
    wr(srsync_pkg::ADDR_CTRL, 32'h0000_0004);
    repeat (400) @(negedge pclk);
    chk(32'(lane_word_valid), 32'h0000_0003);
    wr(srsync_pkg::ADDR_SKEW, 32'h0000_0005);
    rd(srsync_pkg::ADDR_SKEW, 32'h0000_0005, 1'b0);
    wr(srsync_pkg::ADDR_CTRL, 32'h0000_0001);
    wait_req(1'b0, 10);
    end_of_test();
  end

  // watchdog well beyond two bring-ups and two full reference periods
  initial
  begin
    repeat (60000) @(posedge pclk);
    miscompares++;
    end_of_test();
  end
endmodule
